// >>> src/nrc_pkg.sv
package nrc_pkg;
   // Clock and pin timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int T_WE_LOW_NS = 25;
   localparam int T_WE_HIGH_NS = 15;
   localparam int T_RD_LOW_NS = 25;
   localparam int T_RD_HIGH_NS = 15;
   localparam int T_WE_TO_BUSY_NS = 100;
   localparam int WE_LOW_CYC = (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WE_HIGH_CYC = (T_WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RD_LOW_CYC = (T_RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RD_HIGH_CYC = (T_RD_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WB_CYC = (T_WE_TO_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_STAGES = 2;
   // Read strobe stays low long enough for data to pass the synchroniser
   localparam int RD_HOLD_CYC = RD_LOW_CYC + SYNC_STAGES;

   // Device command codes
   localparam logic [7:0] CMD_READ_SETUP = 8'h00;
   localparam logic [7:0] CMD_READ_GO = 8'h30;
   localparam logic [7:0] CMD_CACHE_NEXT = 8'h31;
   localparam logic [7:0] CMD_CACHE_LAST = 8'h3f;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_RESET = 8'hff;
   localparam logic [7:0] CMD_COL_SETUP = 8'h05;
   localparam logic [7:0] CMD_COL_GO = 8'he0;

   // Controller operations written to the control register
   localparam logic [3:0] OP_NONE = 4'h0;
   localparam logic [3:0] OP_PAGE_READ = 4'h1;
   localparam logic [3:0] OP_CACHE_SEQ = 4'h2;
   localparam logic [3:0] OP_CACHE_RAND = 4'h3;
   localparam logic [3:0] OP_CACHE_LAST = 4'h4;
   localparam logic [3:0] OP_STATUS = 4'h5;
   localparam logic [3:0] OP_RESET = 4'h6;
   localparam logic [3:0] OP_COLUMN = 4'h7;
   localparam logic [3:0] OP_READ = 4'h8;
   localparam logic [3:0] OP_READ_RR = 4'h9;

   // Sequence item kinds
   localparam logic [1:0] K_CMD = 2'h0;
   localparam logic [1:0] K_ADDR = 2'h1;
   localparam logic [1:0] K_WAIT = 2'h2;
   localparam logic [1:0] K_READ = 2'h3;

   // Register byte offsets
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_COL = 5'h04;
   localparam logic [4:0] REG_ROW = 5'h08;
   localparam logic [4:0] REG_STAT = 5'h0c;
   localparam logic [4:0] REG_DATA = 5'h10;

   // Status register fields
   localparam int STB_BUSY = 0;
   localparam int STB_READY = 1;
   localparam int STB_ERR = 2;
   localparam int STB_CACHE = 3;
   localparam int STB_LOADED = 4;
   localparam int STB_REREAD = 5;
   localparam int STB_NSTAT_LSB = 16;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ITEM = 3'b001,
      ST_LOW = 3'b010,
      ST_HIGH = 3'b011,
      ST_WB = 3'b100,
      ST_RDY = 3'b101,
      ST_DONE = 3'b110
   } nrc_state_t;
endpackage : nrc_pkg

// >>> src/nrc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module nrc_sync
   import nrc_pkg::*;
#(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_r;

   // Two-stage synchroniser; the first stage feeds only the second
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         meta_r <= '0;
         o_q <= '0;
      end else begin
         meta_r <= i_d;
         o_q <= meta_r;
      end
   end
endmodule : nrc_sync
`default_nettype wire

// >>> src/nrc_host.sv
// How it works
// - Page read sends 00h, four address bytes, then 30h.
// - Controller waits for ready high before any data read.
// - After a status read with a page loaded, a data read first resends 00h.
// - During data reads command, address and chip enable low, write high.
// - Only defined command codes are ever sent; unknown operations refused.
// - Column change is used only once a page is loaded.
// - Cache reading begins with an ordinary page read.
//
// Our own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module nrc_host
   import nrc_pkg::*;
#(
   parameter int DW = 16
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic o_cle,
   output logic o_ale,
   output logic o_ce_n,
   output logic o_we_n,
   output logic o_read_strobe_n,
   output logic o_wp_n,
   input wire logic [DW-1:0] i_io,
   output logic [DW-1:0] o_io,
   output logic o_io_oe,
   input wire logic i_ready_busy_n
);
   nrc_state_t state_r;
   logic [3:0] op_r;
   logic [2:0] idx_r;
   logic [4:0] cnt_r;
   logic [15:0] col_r;
   logic [15:0] row_r;
   logic [DW-1:0] data_r;
   logic [7:0] nstat_r;
   logic cache_mode_r;
   logic loaded_r;
   logic reread_r;
   logic err_r;
   logic [DW:0] sync_q;
   logic ready_s;
   logic [DW-1:0] io_s;
   logic [10:0] item;
   logic [1:0] kind;
   logic last;
   logic [7:0] val;
   logic ctrl_wr;
   logic [3:0] req_op;
   logic start;
   logic [31:0] stat_w;
   logic [31:0] rdata_w;

   nrc_sync #(.W(DW + 1)) u_sync (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_d({i_ready_busy_n, i_io}),
      .o_q(sync_q)
   );
   assign ready_s = sync_q[DW];
   assign io_s = sync_q[DW-1:0];

   // Step list for each operation: {kind, last, command or address index}
   function automatic logic [10:0] seq_item(input logic [3:0] op,
                                            input logic [2:0] i);
      logic [10:0] r;
      r = {K_WAIT, 1'b1, 8'h00};
      case (op)
         OP_PAGE_READ, OP_CACHE_RAND: begin
            if (i == 3'd0) r = {K_CMD, 1'b0, CMD_READ_SETUP};
            else if (i < 3'd5) r = {K_ADDR, 1'b0, 5'h00, 3'(i - 3'd1)};
            else if (i == 3'd5)
               r = {K_CMD, 1'b0, (op == OP_PAGE_READ) ? CMD_READ_GO :
                    CMD_CACHE_NEXT};
         end
         OP_CACHE_SEQ: if (i == 3'd0) r = {K_CMD, 1'b0, CMD_CACHE_NEXT};
         OP_CACHE_LAST: if (i == 3'd0) r = {K_CMD, 1'b0, CMD_CACHE_LAST};
         OP_RESET: if (i == 3'd0) r = {K_CMD, 1'b0, CMD_RESET};
         OP_STATUS: begin
            if (i == 3'd0) r = {K_CMD, 1'b0, CMD_STATUS};
            else r = {K_READ, 1'b1, 8'h00};
         end
         OP_COLUMN: begin
            if (i == 3'd0) r = {K_CMD, 1'b0, CMD_COL_SETUP};
            else if (i < 3'd3) r = {K_ADDR, 1'b0, 5'h00, 3'(i - 3'd1)};
            else r = {K_CMD, 1'b1, CMD_COL_GO};
         end
         OP_READ: r = {K_READ, 1'b1, 8'h00};
         OP_READ_RR: begin
            if (i == 3'd0) r = {K_CMD, 1'b0, CMD_READ_SETUP};
            else r = {K_READ, 1'b1, 8'h00};
         end
         default: r = {K_WAIT, 1'b1, 8'h00};
      endcase
      return r;
   endfunction : seq_item

   function automatic logic [7:0] addr_byte(input logic [2:0] i,
                                            input logic [15:0] c,
                                            input logic [15:0] rw);
      logic [7:0] b;
      b = 8'h00;
      if (i == 3'd0) b = c[7:0];
      else if (i == 3'd1) b = c[15:8];
      else if (i == 3'd2) b = rw[7:0];
      else b = rw[15:8];
      return b;
   endfunction : addr_byte

   function automatic logic op_ok(input logic [3:0] op, input logic rdy,
                                  input logic cm, input logic ld);
      logic ok;
      case (op)
         OP_PAGE_READ, OP_READ: ok = rdy;
         OP_STATUS, OP_RESET: ok = 1'b1;
         OP_CACHE_SEQ, OP_CACHE_RAND, OP_CACHE_LAST: ok = rdy & cm;
         OP_COLUMN: ok = rdy & ld;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : op_ok

   assign item = seq_item(op_r, idx_r);
   assign kind = item[10:9];
   assign last = item[8];
   assign val = item[7:0];

   assign ctrl_wr = i_avs_write & ~o_avs_waitrequest &
                    (i_avs_address == REG_CTRL);
   assign req_op = i_avs_writedata[3:0];
   assign start = ctrl_wr & (state_r == ST_IDLE) &
                  op_ok(req_op, ready_s, cache_mode_r, loaded_r);

   // Pin sequencer
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         state_r <= ST_IDLE;
         op_r <= OP_NONE;
         idx_r <= 3'h0;
         cnt_r <= 5'h00;
         o_cle <= 1'b0;
         o_ale <= 1'b0;
         o_ce_n <= 1'b1;
         o_we_n <= 1'b1;
         o_read_strobe_n <= 1'b1;
         o_io <= '0;
         o_io_oe <= 1'b0;
         data_r <= '0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (start) begin
                  op_r <= (req_op == OP_READ && reread_r) ? OP_READ_RR : req_op;
                  idx_r <= 3'h0;
                  o_ce_n <= 1'b0;
                  state_r <= ST_ITEM;
               end
            end
            ST_ITEM: begin
               if (kind == K_CMD || kind == K_ADDR) begin
                  o_cle <= (kind == K_CMD);
                  o_ale <= (kind == K_ADDR);
                  o_we_n <= 1'b0;
                  o_io_oe <= 1'b1;
                  o_io <= DW'((kind == K_CMD) ? val :
                              addr_byte(val[2:0], col_r, row_r));
                  cnt_r <= 5'(WE_LOW_CYC - 1);
                  state_r <= ST_LOW;
               end else if (kind == K_READ) begin
                  o_read_strobe_n <= 1'b0;
                  cnt_r <= 5'(RD_HOLD_CYC - 1);
                  state_r <= ST_LOW;
               end else begin
                  cnt_r <= 5'(WB_CYC - 1);
                  state_r <= ST_WB;
               end
            end
            ST_LOW: begin
               if (cnt_r != 5'h00) begin
                  cnt_r <= cnt_r - 5'h01;
               end else if (kind == K_READ) begin
                  data_r <= io_s;
                  o_read_strobe_n <= 1'b1;
                  cnt_r <= 5'(RD_HIGH_CYC - 1);
                  state_r <= ST_HIGH;
               end else begin
                  o_we_n <= 1'b1;
                  cnt_r <= 5'(WE_HIGH_CYC - 1);
                  state_r <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (cnt_r != 5'h00) begin
                  cnt_r <= cnt_r - 5'h01;
               end else begin
                  o_cle <= 1'b0;
                  o_ale <= 1'b0;
                  o_io_oe <= 1'b0;
                  idx_r <= idx_r + 3'h1;
                  state_r <= last ? ST_DONE : ST_ITEM;
               end
            end
            ST_WB: begin
               if (cnt_r != 5'h00) cnt_r <= cnt_r - 5'h01;
               else state_r <= ST_RDY;
            end
            ST_RDY: begin
               if (ready_s) state_r <= ST_DONE;
            end
            default: begin
               o_ce_n <= 1'b1;
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Read mode flags, kept in step with what the device holds
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         cache_mode_r <= 1'b0;
         loaded_r <= 1'b0;
         reread_r <= 1'b0;
         nstat_r <= 8'h00;
      end else if (state_r == ST_DONE) begin
         case (op_r)
            OP_PAGE_READ, OP_CACHE_SEQ, OP_CACHE_RAND: begin
               cache_mode_r <= 1'b1;
               loaded_r <= 1'b1;
               reread_r <= 1'b0;
            end
            OP_CACHE_LAST: cache_mode_r <= 1'b0;
            OP_RESET: begin
               cache_mode_r <= 1'b0;
               loaded_r <= 1'b0;
               reread_r <= 1'b0;
            end
            OP_STATUS: begin
               nstat_r <= data_r[7:0];
               reread_r <= loaded_r;
            end
            OP_READ_RR: reread_r <= 1'b0;
            default: reread_r <= reread_r;
         endcase
      end
   end

   // Column pointer mirrors the device's in every operation except OP_RESET, which leaves it unchanged
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         col_r <= 16'h0000;
      end else if (i_avs_write && !o_avs_waitrequest &&
                   i_avs_address == REG_COL) begin
         col_r <= i_avs_writedata[15:0];
      end else if (state_r == ST_DONE && (op_r == OP_CACHE_SEQ ||
                   op_r == OP_CACHE_RAND || op_r == OP_CACHE_LAST)) begin
         col_r <= 16'h0000;
      end else if (state_r == ST_LOW && kind == K_READ && cnt_r == 5'h00 &&
                   op_r != OP_STATUS) begin
         col_r <= col_r + 16'h0001;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) row_r <= 16'h0000;
      else if (i_avs_write && !o_avs_waitrequest && i_avs_address == REG_ROW)
         row_r <= i_avs_writedata[15:0];
   end

   // Refused request flag; a new refusal wins over a clear
   always_ff @(posedge i_clk) begin
      if (!i_nrst) err_r <= 1'b0;
      else if (ctrl_wr && !start) err_r <= 1'b1;
      else if (i_avs_write && !o_avs_waitrequest &&
               i_avs_address == REG_STAT && i_avs_writedata[STB_ERR])
         err_r <= 1'b0;
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) o_wp_n <= 1'b0;
      else o_wp_n <= 1'b0;
   end

   always_comb begin
      stat_w = 32'h0000_0000;
      stat_w[STB_BUSY] = (state_r != ST_IDLE);
      stat_w[STB_READY] = ready_s;
      stat_w[STB_ERR] = err_r;
      stat_w[STB_CACHE] = cache_mode_r;
      stat_w[STB_LOADED] = loaded_r;
      stat_w[STB_REREAD] = reread_r;
      stat_w[STB_NSTAT_LSB +: 8] = nstat_r;
      if (i_avs_address == REG_CTRL) rdata_w = {28'h0000000, op_r};
      else if (i_avs_address == REG_COL) rdata_w = {16'h0000, col_r};
      else if (i_avs_address == REG_ROW) rdata_w = {16'h0000, row_r};
      else if (i_avs_address == REG_STAT) rdata_w = stat_w;
      else if (i_avs_address == REG_DATA) rdata_w = 32'(data_r);
      else rdata_w = 32'h0000_0000;
   end

   // Avalon slave: each request answered one cycle after it appears
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h0000_0000;
      end else begin
         o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & o_avs_waitrequest);
         if (i_avs_read && o_avs_waitrequest) o_avs_readdata <= rdata_w;
      end
   end

   a_we_pulse_len: assert property (@(posedge i_clk) disable iff (!i_nrst)
      $fell(o_we_n) |-> (!o_we_n) [*4] ##1 o_we_n)
      else $error("write strobe low time wrong");
   a_rd_pulse_len: assert property (@(posedge i_clk) disable iff (!i_nrst)
      $fell(o_read_strobe_n) |-> (!o_read_strobe_n) [*6] ##1 o_read_strobe_n)
      else $error("read strobe low time wrong");
   a_read_pins: assert property (@(posedge i_clk) disable iff (!i_nrst)
      !o_read_strobe_n |-> !o_cle && !o_ale && !o_ce_n && o_we_n && !o_io_oe)
      else $error("pins wrong during data read");
   a_latch_sel: assert property (@(posedge i_clk) disable iff (!i_nrst)
      !o_we_n |-> (o_cle ^ o_ale) && o_io_oe && !o_ce_n)
      else $error("write strobe without one latch enable");
   a_wp_low: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ##1 !o_wp_n)
      else $error("write protect released");
   a_ready_exit: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (state_r == ST_RDY) && !ready_s |=> (state_r == ST_RDY))
      else $error("left busy wait before ready");
   a_busy_refuse: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ctrl_wr && !ready_s && req_op != OP_STATUS && req_op != OP_RESET
      |=> err_r && $stable(op_r))
      else $error("operation accepted while device busy");
   a_reread_first: assert property (@(posedge i_clk) disable iff (!i_nrst)
      start && req_op == OP_READ && reread_r |=> ##1 o_cle ##[1:8] !o_we_n)
      else $error("read setup not resent after status");
   a_cache_gate: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ctrl_wr && !cache_mode_r && (req_op == OP_CACHE_SEQ ||
      req_op == OP_CACHE_LAST) |=> err_r && state_r == ST_IDLE)
      else $error("cache command outside cache mode");
   a_bus_answer: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
      else $error("bus answer timing wrong");
endmodule : nrc_host
`default_nettype wire

// >>> verif/nrc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module nrc_flash_model #(
   parameter int BUSY_NS = 1500
) (
   input wire logic i_ce_n,
   input wire logic i_cle,
   input wire logic i_ale,
   input wire logic i_we_n,
   input wire logic i_read_strobe_n,
   input wire logic [15:0] i_io,
   output logic [15:0] o_dq,
   output logic o_rb_low,
   output int o_bad
);
   logic [15:0] col, arow, drow, crow, last;
   logic bsy, cmode, stat_mode, rd_on;
   logic [7:0] sts, sts_nxt;
   int acnt;
   event go_busy;
   function automatic logic [15:0] word(input logic [15:0] r,
                                        input logic [15:0] c);
      return {r[7:0] ^ 8'h5a, c[7:0]};
   endfunction : word
   // Read mode from power-up
   initial begin
      col = 16'h0000;
      arow = 16'h0000;
      drow = 16'h0000;
      crow = 16'h0000;
      last = 16'h0000;
      o_dq = 16'hffff;
      bsy = 1'b0;
      cmode = 1'b0;
      stat_mode = 1'b0;
      rd_on = 1'b0;
      sts = 8'h60;
      sts_nxt = 8'h60;
      acnt = 0;
      o_rb_low = 1'b0;
      o_bad = 0;
   end
   // Command latch; only status and reset pass while busy
   always @(posedge i_we_n) begin
      if (!i_ce_n && i_cle && (!bsy || i_io[7:0] == 8'h70 ||
          i_io[7:0] == 8'hff)) begin
         if (i_io[7:0] != 8'h70)
            stat_mode = 1'b0;
         case (i_io[7:0])
            8'h00: acnt = 0;
            8'h30: begin
               drow = arow;
               crow = arow;
               cmode = 1'b1;
               acnt = 0;
               sts_nxt = 8'h60;
               ->go_busy;
            end
            8'h31: if (cmode) begin
               crow = drow;
               drow = (acnt == 4) ? arow : drow + 16'h0001;
               col = 16'h0000;
               acnt = 0;
               sts_nxt = 8'h40;
               ->go_busy;
            end
            8'h3f: if (cmode) begin
               crow = drow;
               col = 16'h0000;
               cmode = 1'b0;
               sts_nxt = 8'h60;
               ->go_busy;
            end
            8'h70: stat_mode = 1'b1;
            8'h05: acnt = 0;
            8'hff: begin
               cmode = 1'b0;
               col = 16'h0000;
               acnt = 0;
               sts_nxt = 8'h60;
               ->go_busy;
            end
            default: ;
         endcase
      end
   end
   // Address cycles: column low, column high, row low, row high
   always @(posedge i_we_n) begin
      if (!i_ce_n && i_ale && !bsy) begin
         case (acnt)
            0: col[7:0] = i_io[7:0];
            1: col[15:8] = i_io[7:0];
            2: arow[7:0] = i_io[7:0];
            3: arow[15:8] = i_io[7:0];
            default: ;
         endcase
         acnt++;
      end
   end
   // Busy pulse on the open-drain line, status bits 6:5 zero meanwhile
   always begin
      @(go_busy);
      bsy = 1'b1;
      #40;
      o_rb_low = 1'b1;
      sts = 8'h00;
      #(BUSY_NS);
      sts = sts_nxt;
      o_rb_low = 1'b0;
      bsy = 1'b0;
   end
   // Data out from the cache register; garbage while busy
   always @(negedge i_read_strobe_n) begin
      if (i_cle || i_ale || i_ce_n || !i_we_n)
         o_bad++;
      rd_on = 1'b1;
      #10;
      if (bsy)
         last = ~last;
      else if (stat_mode)
         last = {8'h00, sts};
      else
         last = word(crow, col);
      o_dq = last;
   end
   // Released bus shows the inverse of the last word
   always @(posedge i_read_strobe_n) begin
      // A pin leaving its unknown start value is not a pulse
      if (rd_on && !bsy && !stat_mode)
         col = col + 16'h0001;
      rd_on = 1'b0;
      #5;
      o_dq = ~last;
   end
endmodule : nrc_flash_model
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import nrc_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [4:0] adr = 5'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, v;
   logic wreq, cle, ale, ce_n, we_n, re_n, wp_n, oe, rb_low, rb;
   logic [15:0] dio, dq, io_in;
   int bad;
   int fails = 0;
   int num_checks = 0;
   always #4 clk = ~clk;
   assign io_in = oe ? dio : dq;
   assign rb = ~rb_low;
   nrc_host #(.DW(16)) dut (.i_clk(clk), .i_nrst(nrst),
      .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wdata), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wreq), .o_cle(cle), .o_ale(ale), .o_ce_n(ce_n),
      .o_we_n(we_n), .o_read_strobe_n(re_n), .o_wp_n(wp_n), .i_io(io_in),
      .o_io(dio), .o_io_oe(oe), .i_ready_busy_n(rb));
   nrc_flash_model #(.BUSY_NS(1500)) flash (.i_ce_n(ce_n), .i_cle(cle),
      .i_ale(ale), .i_we_n(we_n), .i_read_strobe_n(re_n), .i_io(io_in),
      .o_dq(dq), .o_rb_low(rb_low), .o_bad(bad));
   task automatic close_out();
      if (fails == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out
   task automatic chk_word(input string n, input logic [31:0] e,
                           input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask : chk_word
   task automatic chk_bit(input string n, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %b seen %b", n, e, g);
      end
   endtask : chk_bit
   task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      adr <= a;
      wdata <= d;
      wr <= 1'b1;
      do @(posedge clk); while (wreq !== 1'b0);
      wr <= 1'b0;
   endtask : bus_wr
   task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge clk);
      adr <= a;
      rd <= 1'b1;
      do @(posedge clk); while (wreq !== 1'b0);
      d = rdata;
      rd <= 1'b0;
   endtask : bus_rd
   task automatic rd_chk(input string n, input logic [4:0] a,
                         input logic [31:0] e);
      logic [31:0] d;
      bus_rd(a, d);
      chk_word(n, e, d);
   endtask : rd_chk
   // Start an operation, wait for the controller, check masked flags
   task automatic do_op(input logic [3:0] op, input logic [5:0] fl,
                        input logic [5:0] m);
      logic [31:0] s;
      int n;
      bus_wr(REG_CTRL, {28'h0, op});
      s = 32'h1;
      n = 0;
      while (s[STB_BUSY] !== 1'b0 && n < 3000) begin
         bus_rd(REG_STAT, s);
         n++;
      end
      chk_bit("op done", 1'b0, s[STB_BUSY]);
      chk_word("stat flags", {26'h0, fl}, {26'h0, s[5:0] & m});
   endtask : do_op
   task automatic read_word(input logic [15:0] e);
      do_op(OP_READ, 6'h00, 6'h04);
      rd_chk("data", REG_DATA, {16'h0, e});
   endtask : read_word
   task automatic stat_byte(input logic [7:0] e);
      logic [31:0] s;
      bus_rd(REG_STAT, s);
      chk_word("flash status", {24'h0, e}, {24'h0, s[23:16]});
   endtask : stat_byte
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      close_out();
   end
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      rd_chk("stat", REG_STAT, 32'h00000002);
      rd_chk("col", REG_COL, 32'h0);
      read_word(16'h5a00);
      read_word(16'h5a01);
      bus_wr(REG_COL, 32'h0003);
      bus_wr(REG_ROW, 32'h0012);
      rd_chk("row", REG_ROW, 32'h0012);
      do_op(OP_PAGE_READ, 6'h1a, 6'h3f);
      read_word(16'h4803);
      read_word(16'h4804);
      do_op(OP_STATUS, 6'h3a, 6'h3f);
      stat_byte(8'h60);
      read_word(16'h4805);
      bus_wr(REG_COL, 32'h0010);
      do_op(OP_COLUMN, 6'h00, 6'h04);
      read_word(16'h4810);
      do_op(OP_CACHE_SEQ, 6'h18, 6'h1c);
      rd_chk("col", REG_COL, 32'h0);
      read_word(16'h4800);
      do_op(OP_STATUS, 6'h00, 6'h04);
      stat_byte(8'h40);
      do_op(OP_CACHE_SEQ, 6'h18, 6'h1c);
      read_word(16'h4900);
      bus_wr(REG_COL, 32'h0077);
      bus_wr(REG_ROW, 32'h0040);
      do_op(OP_CACHE_RAND, 6'h18, 6'h1c);
      read_word(16'h4e00);
      do_op(OP_CACHE_LAST, 6'h10, 6'h1c);
      read_word(16'h1a00);
      do_op(OP_STATUS, 6'h00, 6'h04);
      stat_byte(8'h60);
      do_op(OP_CACHE_SEQ, 6'h04, 6'h0c);
      bus_wr(REG_STAT, 32'h4);
      do_op(4'ha, 6'h04, 6'h04);
      bus_wr(REG_STAT, 32'h4);
      // Data read requested while the flash is busy must be refused
      bus_wr(REG_CTRL, {28'h0, OP_PAGE_READ});
      v = 32'h2;
      while (v[STB_READY] !== 1'b0) bus_rd(REG_STAT, v);
      bus_wr(REG_CTRL, {28'h0, OP_READ});
      v = 32'h1;
      while (v[STB_BUSY] !== 1'b0) bus_rd(REG_STAT, v);
      chk_word("busy refusal", 32'h1c, v & 32'h1c);
      bus_wr(REG_STAT, 32'h4);
      do_op(OP_RESET, 6'h00, 6'h0c);
      bus_rd(REG_CTRL, v);
      chk_word("ctrl", 32'h6, v & 32'hf);
      rd_chk("unmapped", 5'h14, 32'h0);
      rd_chk("unmapped", 5'h1c, 32'h0);
      chk_bit("wp_n", 1'b0, wp_n);
      chk_word("read pin faults", 32'h0, bad);
      close_out();
   end
endmodule : tb
`default_nettype wire
